// *** hdl/tae_pkg.sv ***
// Purpose: Shared constants and types for the thermal alarm event block.
// Assumes: 10 MHz system clock, 13-bit two's complement temperature.
// Notes:   Register pointers, config fields, masks and reset values live here.
`default_nettype none

package tae_pkg;
  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_MS = 125;
  // Longest period rounds down to whole cycles
  localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_MS;

  // -------------------------------------------------------------------
  // Register pointers and bus address
  // -------------------------------------------------------------------
  localparam logic [7:0] PTR_CFG = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [3:0] ADDR_FIXED = 4'h3;

  // -------------------------------------------------------------------
  // Config fields, masks and reset values
  // -------------------------------------------------------------------
  localparam int CFG_MODE = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_EN = 3;
  localparam int CFG_CLR = 5;
  localparam int CFG_WLOCK = 6;
  localparam int CFG_CLOCK = 7;
  localparam int CFG_HYS_LO = 9;
  localparam int CFG_HYS_HI = 10;
  localparam logic [15:0] CFG_WMASK = 16'h06CF;
  localparam logic [15:0] LOCK_MASK = 16'h00C0;
  localparam logic [15:0] KEEP_MASK = 16'h0005;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [12:0] TEMP_RST = 13'h0000;
  // Hysteresis in 1/16 degree steps: 0, 1.5, 3, 6 degrees
  localparam logic [12:0] HYS_0 = 13'h0000;
  localparam logic [12:0] HYS_1P5 = 13'h0018;
  localparam logic [12:0] HYS_3 = 13'h0030;
  localparam logic [12:0] HYS_6 = 13'h0060;

  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic scl;
    logic sda;
  } tae_pins_t;
  localparam logic [4:0] PIN_IDLE = 5'h03;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_PTR, S_PACK, S_WR, S_WACK, S_RD, S_RACK
  } tae_state_t;
endpackage

`default_nettype wire

// *** hdl/tae_top.sv ***
// Purpose: Temperature alarm logic with serial register access.
// Assumes: adc_temp is valid on sys_clk; bus pins are asynchronous.
// Notes:   Alarm pin and data pin are open drain (output held low).
// Functional notes
// - Comparator mode alarms outside window, or above critical when critical-only.
// - Comparator mode alarm ignores register reads and writes.
// - Comparator alarm holds until temperature or new limits put it inside.
// - Interrupt mode alarms on every window bound crossing, either direction.
// - Writing one to clear-alarm bit drops interrupt alarm until next trigger.
// - Enabled alarm asserts at critical, holds until below critical less hysteresis.
// - Clear bit and alert response cannot drop alarm at or above critical.
// - After clearing upper crossing, rising past critical reasserts alarm.
// - Falling below critical drops interrupt alarm at once, no clear needed; a window crossing in the same conversion sets it instead.
// - In critical region alarm acts as comparator; mode bit ignored.
// - Temperature word bits 15, 14, 13 flag critical, above, below.
// - Hysteresis applies; critical releases only past trip less hysteresis, upper at it, lower trips only past bound less hysteresis.
// - Critical-only band ignores upper and lower bounds.
// - New limits take effect only at the next conversion.
// - A conversion completes at least every 125 ms.
// - Temperature read returns newest completed conversion.
// - Conversion mid-read does not change bytes being shifted out.
// - Upper bound at pointer 02h, lower at 03h, critical at 04h.
// - Interrupt-mode window alarm drops on clear-bit write or alert response.
// - Config bits select mode, band, hysteresis and two limit locks.
// - Config bits set polarity, enable, status and clear; pin off at reset.
// - Hysteresis field picks 0, 1.5, 3 or 6 degrees.
`default_nettype none

module tae_top #(
  parameter int unsigned CONV_CYCLES = tae_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Converter sample
  input wire logic [12:0] adc_temp,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] addr_pins,
  // Alert response accepted by framing logic
  input wire logic alert_ack,
  // Alarm pin
  output logic alarm_out,
  output logic alarm_oe,
  // Conversion strobe
  output logic conv_done
);
  localparam logic [20:0] CONV_LAST = 21'(CONV_CYCLES - 1);

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  tae_pkg::tae_pins_t pin_raw, s1_ff, s2_ff, s3_ff, pin_ff, prv_ff, nxt_pin;
  assign pin_raw = {addr_pins, scl_in, sda_in};
  // A level is taken once the second and third stages agree
  assign nxt_pin = (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= tae_pkg::PIN_IDLE;
      s2_ff <= tae_pkg::PIN_IDLE;
      s3_ff <= tae_pkg::PIN_IDLE;
      pin_ff <= tae_pkg::PIN_IDLE;
      prv_ff <= tae_pkg::PIN_IDLE;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= nxt_pin;
      prv_ff <= pin_ff;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  // Bus events from the filtered levels
  assign scl_rise = pin_ff.scl & ~prv_ff.scl;
  assign scl_fall = ~pin_ff.scl & prv_ff.scl;
  assign bus_start = pin_ff.scl & prv_ff.scl & prv_ff.sda & ~pin_ff.sda;
  assign bus_stop = pin_ff.scl & prv_ff.scl & ~prv_ff.sda & pin_ff.sda;

  // -------------------------------------------------------------------
  // Serial slave
  // -------------------------------------------------------------------
  tae_pkg::tae_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, msb_ff, nxt_msb;
  logic [15:0] tx_ff, nxt_tx, rd_word, wdata;
  logic oe_ff, nxt_oe, rw_ff, nxt_rw, nack_ff, nxt_nack, lsb_ff, nxt_lsb, wr_stb;
  logic addr_hit;
  assign addr_hit = sh_ff[7:1] == {tae_pkg::ADDR_FIXED, pin_ff.addr};
  assign wdata = {msb_ff, sh_ff};

  // Byte framing, acknowledge and shift control
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_oe = oe_ff;
    nxt_ptr = ptr_ff;
    nxt_msb = msb_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    nxt_lsb = lsb_ff;
    wr_stb = 1'b0;
    if (bus_stop) begin
      nxt_state = tae_pkg::S_IDLE;
      nxt_oe = 1'b0;
    end else if (bus_start) begin
      nxt_state = tae_pkg::S_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (scl_rise) begin
      nxt_sh = {sh_ff[6:0], pin_ff.sda};
      nxt_cnt = cnt_ff + 4'h1;
      if (state_ff == tae_pkg::S_RACK) nxt_nack = pin_ff.sda;
    end else if (scl_fall) begin
      case (state_ff)
        tae_pkg::S_ADDR: if (cnt_ff == 4'h8) begin
          nxt_state = addr_hit ? tae_pkg::S_AACK : tae_pkg::S_IDLE;
          nxt_oe = addr_hit;
          nxt_rw = sh_ff[0];
        end
        tae_pkg::S_AACK: begin
          nxt_cnt = 4'h0;
          nxt_state = rw_ff ? tae_pkg::S_RD : tae_pkg::S_PTR;
          nxt_tx = rd_word;
          nxt_oe = rw_ff & ~rd_word[15];
        end
        tae_pkg::S_PTR: if (cnt_ff == 4'h8) begin
          nxt_ptr = sh_ff;
          nxt_oe = 1'b1;
          nxt_state = tae_pkg::S_PACK;
        end
        tae_pkg::S_PACK: begin
          nxt_oe = 1'b0;
          nxt_cnt = 4'h0;
          nxt_lsb = 1'b0;
          nxt_state = tae_pkg::S_WR;
        end
        tae_pkg::S_WR: if (cnt_ff == 4'h8) begin
          nxt_oe = 1'b1;
          nxt_state = tae_pkg::S_WACK;
          wr_stb = lsb_ff;
          if (!lsb_ff) nxt_msb = sh_ff;
        end
        tae_pkg::S_WACK: begin
          nxt_oe = 1'b0;
          nxt_cnt = 4'h0;
          nxt_lsb = ~lsb_ff;
          nxt_state = tae_pkg::S_WR;
        end
        tae_pkg::S_RD: if (cnt_ff == 4'h8) begin
          nxt_oe = 1'b0;
          nxt_state = tae_pkg::S_RACK;
        end else begin
          nxt_tx = {tx_ff[14:0], 1'b0};
          nxt_oe = ~tx_ff[14];
        end
        tae_pkg::S_RACK: begin
          nxt_cnt = 4'h0;
          nxt_state = nack_ff ? tae_pkg::S_IDLE : tae_pkg::S_RD;
          nxt_tx = {tx_ff[14:0], 1'b0};
          nxt_oe = ~nack_ff & ~tx_ff[14];
        end
        default: nxt_state = tae_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= tae_pkg::S_IDLE;
      {cnt_ff, sh_ff, ptr_ff, msb_ff} <= '0;
      {tx_ff, oe_ff, rw_ff, nack_ff, lsb_ff} <= '0;
    end else begin
      state_ff <= nxt_state;
      {cnt_ff, sh_ff, ptr_ff, msb_ff} <= {nxt_cnt, nxt_sh, nxt_ptr, nxt_msb};
      {tx_ff, oe_ff, rw_ff, nack_ff, lsb_ff} <= {nxt_tx, nxt_oe, nxt_rw, nxt_nack, nxt_lsb};
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;

  // -------------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------------
  logic [15:0] cfg_ff, cfg_w, nxt_cfg, temp_word;
  logic [12:0] upper_ff, lower_ff, crit_lim_ff, temp_ff;
  logic wr_cfg, wr_up, wr_lo, wr_cr, clr_wr, alarm_act;
  logic crit_ff, above_ff, below_ff;
  // Pointer decode; locks guard the limit registers
  assign wr_cfg = wr_stb && ptr_ff == tae_pkg::PTR_CFG;
  assign wr_up = wr_stb && ptr_ff == tae_pkg::PTR_UPPER && !cfg_ff[tae_pkg::CFG_WLOCK];
  assign wr_lo = wr_stb && ptr_ff == tae_pkg::PTR_LOWER && !cfg_ff[tae_pkg::CFG_WLOCK];
  assign wr_cr = wr_stb && ptr_ff == tae_pkg::PTR_CRIT && !cfg_ff[tae_pkg::CFG_CLOCK];
  assign clr_wr = wr_cfg & wdata[tae_pkg::CFG_CLR];
  // Locks stick until reset; mode and band freeze while enabled
  assign cfg_w = (wdata & tae_pkg::CFG_WMASK) | (cfg_ff & tae_pkg::LOCK_MASK);
  assign nxt_cfg = cfg_ff[tae_pkg::CFG_EN] ?
      (cfg_w & ~tae_pkg::KEEP_MASK) | (cfg_ff & tae_pkg::KEEP_MASK) : cfg_w;
  assign temp_word = {crit_ff, above_ff, below_ff, temp_ff};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= tae_pkg::REG_RST;
      {upper_ff, lower_ff, crit_lim_ff} <= '0;
    end else begin
      if (wr_cfg) cfg_ff <= nxt_cfg;
      if (wr_up) upper_ff <= wdata[12:0];
      if (wr_lo) lower_ff <= wdata[12:0];
      if (wr_cr) crit_lim_ff <= wdata[12:0];
    end
  end

  // Read select; bit 4 of config shows the live alarm state
  always_comb begin
    if (ptr_ff == tae_pkg::PTR_CFG) rd_word = {cfg_ff[15:5], alarm_act, cfg_ff[3:0]};
    else if (ptr_ff == tae_pkg::PTR_UPPER) rd_word = {3'h0, upper_ff};
    else if (ptr_ff == tae_pkg::PTR_LOWER) rd_word = {3'h0, lower_ff};
    else if (ptr_ff == tae_pkg::PTR_CRIT) rd_word = {3'h0, crit_lim_ff};
    else if (ptr_ff == tae_pkg::PTR_TEMP) rd_word = temp_word;
    else rd_word = 16'h0000;
  end

  // -------------------------------------------------------------------
  // Conversion timing and threshold evaluation
  // -------------------------------------------------------------------
  logic [20:0] conv_cnt_ff;
  logic tick, conv_ff, int_ff, nxt_int, crossing, nxt_crit, nxt_above, nxt_below;
  logic en, mode_int, crit_only, aoe_ff;
  logic [12:0] hys;
  logic signed [13:0] t_s, up_s, lo_s, cr_s, hys_s;
  assign tick = conv_cnt_ff == CONV_LAST;
  assign hys = cfg_ff[tae_pkg::CFG_HYS_HI:tae_pkg::CFG_HYS_LO] == 2'h0 ? tae_pkg::HYS_0 :
               cfg_ff[tae_pkg::CFG_HYS_HI:tae_pkg::CFG_HYS_LO] == 2'h1 ? tae_pkg::HYS_1P5 :
               cfg_ff[tae_pkg::CFG_HYS_HI:tae_pkg::CFG_HYS_LO] == 2'h2 ? tae_pkg::HYS_3 :
               tae_pkg::HYS_6;
  assign t_s = {adc_temp[12], adc_temp};
  assign up_s = {upper_ff[12], upper_ff};
  assign lo_s = {lower_ff[12], lower_ff};
  assign cr_s = {crit_lim_ff[12], crit_lim_ff};
  assign hys_s = {1'b0, hys};
  // Critical trips on the bound, upper past it; critical releases past it less hysteresis, upper at it; lower trips past it less hysteresis, releases at it
  assign nxt_crit = crit_ff ? !(t_s < cr_s - hys_s) : (t_s >= cr_s);
  assign nxt_above = above_ff ? !(t_s <= up_s - hys_s) : (t_s > up_s);
  assign nxt_below = below_ff ? !(t_s >= lo_s) : (t_s < lo_s - hys_s);
  assign en = cfg_ff[tae_pkg::CFG_EN];
  assign mode_int = cfg_ff[tae_pkg::CFG_MODE];
  assign crit_only = cfg_ff[tae_pkg::CFG_CRIT_ONLY];
  assign crossing = tick & ~crit_only & ((nxt_above ^ above_ff) | (nxt_below ^ below_ff));
  // A crossing beats a clear in the same cycle; critical exit clears at once
  assign nxt_int = crossing ? 1'b1 :
                   (tick & crit_ff & ~nxt_crit) ? 1'b0 :
                   (clr_wr | alert_ack) ? 1'b0 : int_ff;
  // Critical term bypasses mode and clears; window term follows mode
  assign alarm_act = en & (crit_ff | (~crit_only &
                     (mode_int ? int_ff : (above_ff | below_ff))));

  // Flags and sample move only on a completed conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_ff <= '0;
      {conv_ff, int_ff, aoe_ff, crit_ff, above_ff, below_ff} <= '0;
      temp_ff <= tae_pkg::TEMP_RST;
    end else begin
      conv_cnt_ff <= tick ? 21'h000000 : conv_cnt_ff + 21'h000001;
      conv_ff <= tick;
      int_ff <= nxt_int;
      aoe_ff <= en & (alarm_act ^ cfg_ff[tae_pkg::CFG_POL]);
      if (tick) begin
        {crit_ff, above_ff, below_ff} <= {nxt_crit, nxt_above, nxt_below};
        temp_ff <= adc_temp;
      end
    end
  end
  assign conv_done = conv_ff;
  assign alarm_out = 1'b0;
  assign alarm_oe = aoe_ff;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_crit_pin: assert property (en && crit_ff && !cfg_ff[tae_pkg::CFG_POL] |=> alarm_oe)
    else $error("critical alarm not on pin");
  a_comp_window: assert property (en && !mode_int && !crit_only
    |-> alarm_act == (crit_ff | above_ff | below_ff)) else $error("comparator wrong");
  a_crit_only: assert property (en && crit_only |-> alarm_act == crit_ff)
    else $error("critical-only wrong");
  a_clear_int: assert property (clr_wr && !crossing |=> !int_ff)
    else $error("clear ignored");
  // A window crossing in the same conversion outranks the critical exit
  a_crit_exit: assert property (tick && crit_ff && !nxt_crit
    |=> !crit_ff && int_ff == $past(crossing)) else $error("critical exit kept alarm");
  // In comparator mode the pin follows the flags, not the event latch
  a_cross_set: assert property (crossing |=> int_ff && (alarm_act == en || !mode_int))
    else $error("crossing missed");
  a_flags_hold: assert property (!tick |=> $stable({crit_ff, above_ff, below_ff}))
    else $error("flags moved between conversions");
  a_read_frozen: assert property (state_ff == tae_pkg::S_RD && !scl_fall
    && !bus_start && !bus_stop |=> $stable(tx_ff)) else $error("read data changed");
  a_conv_bound: assert property (conv_cnt_ff <= CONV_LAST)
    else $error("conversion period overrun");
  a_pin_off: assert property (!en |=> !alarm_oe)
    else $error("alarm pin driven while disabled");
  a_lock_hold: assert property (cfg_ff[tae_pkg::CFG_WLOCK] |=> $stable(upper_ff))
    else $error("locked bound changed");
endmodule

`default_nettype wire

// *** test/tae_host.sv ***
// Purpose: Host bus master model for the serial register bus.
// Assumes: Pull-ups on both lines; 800 ns bus clock period.
// Notes:   Drives lines low only; a released line floats high.
`default_nettype none

module tae_host #(
  parameter logic [6:0] DEV_ADDR = 7'h00
) (
  // System clock
  input wire logic clk,
  // Bus lines
  output logic scl_drv,
  output logic sda_drv,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_seen = 1'b0;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // -------------------------------------------------------------------
  // Bit and byte slots
  // -------------------------------------------------------------------
  // Long low phase, short high phase: the device moves its data line
  // five clocks after each falling edge, so the clock stays low for six
  // and the line is settled before the next rising edge
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk);
    sda_drv <= b;
    repeat (4) @(posedge clk);
    scl_drv <= 1'b1;
    repeat (2) @(posedge clk);
    r = sda_line;
    scl_drv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack_seen = ~r;
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // Start: data falls while clock high
  task automatic start_c();
    repeat (4) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (4) @(posedge clk);
    scl_drv <= 1'b0;
  endtask
  // Stop: data rises while clock high, then idle gap
  task automatic stop_c();
    @(posedge clk);
    sda_drv <= 1'b0;
    repeat (3) @(posedge clk);
    scl_drv <= 1'b1;
    repeat (4) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // -------------------------------------------------------------------
  // Transfers
  // -------------------------------------------------------------------
  task automatic wr_word(input logic [7:0] p, input logic [15:0] d);
    start_c();
    tx({DEV_ADDR, 1'b0});
    tx(p);
    tx(d[15:8]);
    tx(d[7:0]);
    stop_c();
  endtask
  task automatic set_ptr(input logic [7:0] p);
    start_c();
    tx({DEV_ADDR, 1'b0});
    tx(p);
    stop_c();
  endtask
  task automatic rd_word(output logic [15:0] d);
    start_c();
    tx({DEV_ADDR, 1'b1});
    rx(1'b0, d[15:8]);
    rx(1'b1, d[7:0]);
    stop_c();
  endtask
endmodule

`default_nettype wire

// *** test/tb.sv ***
// Purpose: Self-checking bench for the thermal alarm block.
// Assumes: Conversion period shortened to 200 cycles.
// Notes:   Alarm checks read the pin drive after two conversions.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 200;
  logic sys_clk, rst_n, alert_ack, scl_drv, sda_drv;
  logic sda_out, sda_oe, alarm_out, alarm_oe, conv_done;
  logic [12:0] adc_temp;
  logic [15:0] rd;
  logic [12:0] hys [4] = '{tae_pkg::HYS_0, tae_pkg::HYS_1P5, tae_pkg::HYS_3, tae_pkg::HYS_6};
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  // Open-drain data wire with pull-up
  wire logic sda_line = sda_drv & ~sda_oe;

  tae_top #(.CONV_CYCLES(CONV)) u_tae_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .adc_temp(adc_temp), .scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pins(3'h5), .alert_ack(alert_ack), .alarm_out(alarm_out),
    .alarm_oe(alarm_oe), .conv_done(conv_done));
  tae_host #(.DEV_ADDR({tae_pkg::ADDR_FIXED, 3'h5})) u_tae_host (.clk(sys_clk),
    .scl_drv(scl_drv), .sda_drv(sda_drv), .sda_line(sda_line));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Count conversion pulses; alarm pin settles one cycle after flags
  task automatic wait_conv(input int k);
    n = 0;
    while (k > 0) begin
      @(posedge sys_clk);
      n++;
      if (conv_done === 1'b1) k--;
      if (n > 1000) begin
        error_cnt++;
        test_done();
      end
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic temp_step(input logic [12:0] t, input logic exp);
    @(posedge sys_clk);
    adc_temp <= t;
    wait_conv(2);
    check({15'h0, alarm_oe}, {15'h0, exp});
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    u_tae_host.wr_word(p, d);
  endtask
  task automatic rc(input logic [7:0] p, input logic [15:0] exp);
    u_tae_host.set_ptr(p);
    u_tae_host.rd_word(rd);
    check(rd, exp);
  endtask
  task automatic ack_pulse();
    @(posedge sys_clk);
    alert_ack <= 1'b1;
    @(posedge sys_clk);
    alert_ack <= 1'b0;
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    alert_ack = 1'b0;
    adc_temp = 13'h0300;
    repeat (6) @(posedge sys_clk);
    check({12'h0, sda_out, alarm_out, alarm_oe, sda_oe}, 16'h0000);
    rst_n <= 1'b1;
    rc(8'h01, tae_pkg::REG_RST);
    rc(8'h04, tae_pkg::REG_RST);
    // Limits in ascending order; unmapped pointer reads zero
    wr(8'h02, 16'h0520);
    wr(8'h03, 16'h0100);
    wr(8'h04, 16'h0600);
    rc(8'h02, 16'h0520);
    rc(8'h03, 16'h0100);
    rc(8'h04, 16'h0600);
    rc(8'h07, 16'h0000);
    check({15'h0, u_tae_host.ack_seen}, 16'h0001);
    wait_conv(1);
    wait_conv(1);
    check(16'(n), 16'(CONV - 2));
    // Comparator mode, no hysteresis
    wr(8'h01, 16'h0008);
    temp_step(13'h0300, 1'b0);
    temp_step(13'h0530, 1'b1);
    rc(8'h05, 16'h4530);
    check({15'h0, alarm_oe}, 16'h0001);
    wr(8'h01, 16'h0028);
    temp_step(13'h0530, 1'b1);
    wr(8'h02, 16'h0540);
    temp_step(13'h0530, 1'b0);
    temp_step(13'h0080, 1'b1);
    rc(8'h05, 16'h2080);
    // Every hysteresis code: release only at trip less hysteresis
    for (int h = 0; h < 4; h++) begin
      wr(8'h01, {5'h0, h[1:0], 9'h008});
      temp_step(13'h0550, 1'b1);
      temp_step(13'h0541 - hys[h], 1'b1);
      temp_step(13'h0540 - hys[h], 1'b0);
    end
    wr(8'h01, 16'h0208);
    temp_step(13'h0600, 1'b1);
    rc(8'h05, 16'hC600);
    temp_step(13'h05F0, 1'b1);
    rc(8'h05, 16'hC5F0);
    // Interrupt mode: mode bit only changes while output disabled
    wr(8'h01, 16'h0000);
    wr(8'h01, 16'h0001);
    temp_step(13'h0300, 1'b0);
    wr(8'h01, 16'h0029);
    temp_step(13'h0300, 1'b0);
    temp_step(13'h0550, 1'b1);
    wr(8'h01, 16'h0029);
    temp_step(13'h0550, 1'b0);
    temp_step(13'h0300, 1'b1);
    ack_pulse();
    temp_step(13'h0300, 1'b0);
    temp_step(13'h0080, 1'b1);
    wr(8'h01, 16'h0029);
    temp_step(13'h0550, 1'b1);
    wr(8'h01, 16'h0029);
    temp_step(13'h0610, 1'b1);
    wr(8'h01, 16'h0029);
    ack_pulse();
    temp_step(13'h0610, 1'b1);
    temp_step(13'h0550, 1'b0);
    // Critical-only band, then high polarity
    wr(8'h01, 16'h0000);
    wr(8'h01, 16'h0004);
    wr(8'h01, 16'h000C);
    temp_step(13'h0550, 1'b0);
    temp_step(13'h0080, 1'b0);
    temp_step(13'h0610, 1'b1);
    wr(8'h01, 16'h000E);
    temp_step(13'h0610, 1'b0);
    temp_step(13'h0300, 1'b1);
    // A conversion lands while the word is being shifted out
    @(posedge sys_clk);
    adc_temp <= 13'h0310;
    u_tae_host.set_ptr(8'h05);
    wait_conv(1);
    adc_temp <= 13'h0320;
    u_tae_host.rd_word(rd);
    check(rd, 16'h0310);
    u_tae_host.rd_word(rd);
    check(rd, 16'h0320);
    // Locked limits ignore writes
    wr(8'h01, 16'h00CE);
    wr(8'h02, 16'h0400);
    wr(8'h04, 16'h0700);
    rc(8'h02, 16'h0540);
    rc(8'h04, 16'h0600);
    rc(8'h01, 16'h00CE);
    test_done();
  end
endmodule

`default_nettype wire
